/* core/sedac_device.sv */
// Operation
// R01: seven check bits stored with each word
// R02: check code computed internally on writes
// R03: single error corrected, flag if configured
// R04: multi error outputs raw word, flag; the code flags it only while flag_single_sel is low
// R05: check bits never reach the pins
// R06: normal reads never write back
// R07: scrub writes corrected word back
// R08: 19-bit counter, one word per cycle
// R09: scrub visits every address alike
// R10: master initialises whole array before scrub; the bench writes only ten words first
// R11: role select high means master scrub
// R12: master scrub rate programmable 0.433-888kHz
// R13: busy asserted during scrub, master waits
// R14: slave mode scrubs once per request
// R15: hybrid bursts timed by the master
// R16: manual scrub by read then write
// R17: bypass disables correction and scrub
// R18: scrub only with enable low, no bypass
// R19: access field 00 writes, 01 reads
// R20: master writes control word at start
// R21: scrub address wraps to zero
`timescale 1ns/100ps
module sedac_device
   import sedac_pkg::*;
#(
   parameter int SCRUB_FAST = sedac_pkg::SCRUB_FAST_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   sedac_if.dev                        bus,
   output sedac_pkg::sedac_addr_t      scrub_position,
   output logic [sedac_pkg::CTRL_W-1:0] control_word
);
   import sedac_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_HOLD, ST_DONE,
      ST_SCR_WAIT, ST_SCR_READ, ST_SCR_FIX
   } sedac_dev_state_t;

   localparam int PW = ADDR_W + DATA_W + 7;

   function automatic logic [SYN_W-1:0] bit_pos(input int i);
      int p;
      p = i + 3 + int'(i >= 1) + int'(i >= 4) + int'(i >= 11)
          + int'(i >= 26);
      return SYN_W'(p);
   endfunction: bit_pos

   function automatic sedac_chk_t check_code(input sedac_data_t d);
      logic [SYN_W-1:0] s;
      s = '0;
      for (int i = 0; i < DATA_W; i++) begin
         if (d[i]) begin
            s = s ^ bit_pos(i);
         end
      end
      return {^{d, s}, s};
   endfunction: check_code

   function automatic sedac_data_t fix_data(input sedac_data_t d,
                                            input logic [SYN_W-1:0] syn);
      sedac_data_t f;
      f = d;
      for (int i = 0; i < DATA_W; i++) begin
         if (bit_pos(i) == syn) begin
            f[i] = ~d[i];
         end
      end
      return f;
   endfunction: fix_data

   // pin synchronisers
   wire  [PW-1:0]      pin_raw;
   logic [PW-1:0]      pin_s1_reg;
   logic [PW-1:0]      pin_s2_reg;
   sedac_addr_t        a_s;
   sedac_data_t        d_s;
   logic               ce_n_s;
   logic               we_n_s;
   logic               oe_n_s;
   logic               reg_s;
   logic               role_s;
   logic               req_n_s;
   logic               fsel_s;

   sedac_dev_state_t   state_reg;
   sedac_dev_state_t   state_next;
   logic [CTRL_W-1:0]  ctrl_reg;
   logic [CHK_W+DATA_W-1:0] mem [WORDS];
   logic [CHK_W+DATA_W-1:0] rd_word_reg;
   sedac_data_t        dq_out_reg;
   logic               flag_reg;
   logic               taken_reg;
   logic               req_prev_reg;
   logic               pend_reg;
   sedac_addr_t        scrub_ctr_reg;
   sedac_addr_t        last_addr_reg;
   logic [TMR_W-1:0]   timer_reg;
   logic [DLY_W-1:0]   dly_reg;

   assign pin_raw = {bus.addr, bus.dq_bus, bus.ce_n, bus.we_n, bus.oe_n,
                     bus.reg_sel, bus.scrub_role_select,
                     bus.scrub_request_n, bus.flag_single_sel};
   assign {a_s, d_s, ce_n_s, we_n_s, oe_n_s, reg_s, role_s, req_n_s,
           fsel_s} = pin_s2_reg;

   // access decode
   wire acc_go   = !ce_n_s && !taken_reg;
   wire acc_take = (state_reg == ST_IDLE) && acc_go;
   wire [1:0] acc_field = a_s[BIT_ACC_HI:BIT_ACC_LO];
   // R19 control access field
   wire ctrl_wr  = reg_s && !we_n_s && (acc_field == ACC_CTRL_WR);
   wire ctr_rd   = a_s[BIT_ACC_HI] && a_s[BIT_CTR_RD];
   wire ctrl_rd  = acc_field == ACC_CTRL_RD;
   // R17 bypass switch
   wire bypass   = ctrl_reg[BIT_BYPASS];
   // R18 scrub enable gate
   wire scrub_ok = !ctrl_reg[BIT_SCRUB_EN_N] && !bypass;

   // R03 R04 syndrome decode
   wire sedac_data_t rd_data = rd_word_reg[DATA_W-1:0];
   wire sedac_chk_t  rd_chk  = rd_word_reg[CHK_W+DATA_W-1:DATA_W];
   wire sedac_chk_t  calc    = check_code(rd_data);
   wire [SYN_W-1:0]  syn     = calc[SYN_W-1:0] ^ rd_chk[SYN_W-1:0];
   wire err_single = ^rd_word_reg;
   wire err_multi  = !err_single && (syn != '0);
   wire sedac_data_t corr    = err_single ? fix_data(rd_data, syn)
                                          : rd_data;
   wire flag_calc  = !bypass && ((err_single && fsel_s)
                                 || (err_multi && !fsel_s));

   // memory port selection
   wire scr_fix  = state_reg == ST_SCR_FIX;
   // R07 write back on single error
   wire fix_wr   = scr_fix && err_single;
   // R02 R06 only writes and scrub repairs reach the array
   wire mem_we   = (acc_take && !we_n_s && !reg_s) || fix_wr;
   wire sedac_addr_t mem_wa = scr_fix ? scrub_ctr_reg : a_s;
   wire sedac_data_t mem_wd = scr_fix ? corr : d_s;
   wire sedac_addr_t rd_addr = (state_reg == ST_SCR_READ) ? scrub_ctr_reg
                                                          : a_s;

   // R12 master rate timer
   wire [3:0] rate_sel = (ctrl_reg[3:0] > RATE_SEL_MAX) ? RATE_SEL_MAX
                                                        : ctrl_reg[3:0];
   wire [TMR_W-1:0] period = TMR_W'(SCRUB_FAST) << rate_sel;
   wire tick = timer_reg >= period - TMR_W'(1);
   wire [DLY_W-1:0] dly_target = DLY_W'(DLY_MIN_CYC + DLY_STEP_CYC
                                        * int'(ctrl_reg[7:BIT_DLY_LO]));
   // R11 R14 scrub trigger per role
   wire req_fall = req_prev_reg && !req_n_s;
   wire pend_set = scrub_ok && (role_s ? tick : req_fall);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // idle pin levels, no false strobe or request edge
         pin_s1_reg <= PW'(PIN_CTL_IDLE);
         pin_s2_reg <= PW'(PIN_CTL_IDLE);
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (acc_go) begin
               if (!we_n_s) begin
                  state_next = ST_DONE;
               end else begin
                  state_next = reg_s ? ST_HOLD : ST_READ;
               end
            end else if (pend_reg && ce_n_s) begin
               state_next = role_s ? ST_SCR_WAIT : ST_SCR_READ;
            end
         end
         ST_READ:     state_next = ST_HOLD;
         ST_HOLD,
         ST_DONE: begin
            if (ce_n_s) begin
               state_next = ST_IDLE;
            end
         end
         ST_SCR_WAIT: begin
            if (acc_go) begin
               state_next = ST_IDLE;
            end else if (dly_reg >= dly_target) begin
               state_next = ST_SCR_READ;
            end
         end
         ST_SCR_READ: state_next = ST_SCR_FIX;
         ST_SCR_FIX:  state_next = ST_IDLE;
         default:     state_next = ST_IDLE;
      endcase
   end

   // R01 R02 check code stored beside data
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[mem_wa] <= {check_code(mem_wd), mem_wd};
      end
      rd_word_reg <= mem[rd_addr];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg    <= ST_IDLE;
         taken_reg    <= 1'b0;
         req_prev_reg <= 1'b1;
         timer_reg    <= '0;
         dly_reg      <= '0;
      end else begin
         state_reg    <= state_next;
         taken_reg    <= !ce_n_s && (taken_reg || acc_take);
         req_prev_reg <= req_n_s;
         timer_reg    <= (!scrub_ok || !role_s || tick) ? '0
                         : timer_reg + TMR_W'(1);
         dly_reg      <= (state_reg == ST_SCR_WAIT) ? dly_reg + DLY_W'(1)
                                                    : '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RST;
      end else if (acc_take && ctrl_wr) begin
         ctrl_reg <= a_s[CTRL_W-1:0];
      end
   end

   // R05 output data never carries check bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_out_reg <= '0;
         flag_reg   <= 1'b0;
      end else begin
         if (state_reg == ST_READ) begin
            dq_out_reg <= bypass ? rd_data : corr;
         end else if (acc_take && reg_s && we_n_s && ctr_rd) begin
            dq_out_reg <= DATA_W'(last_addr_reg);
         end else if (acc_take && reg_s && we_n_s && ctrl_rd) begin
            dq_out_reg <= DATA_W'(ctrl_reg);
         end
         flag_reg <= (state_reg == ST_READ) ? flag_calc
                     : (flag_reg && !ce_n_s);
      end
   end

   // R08 R09 R21 sequential walk of all words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_reg      <= 1'b0;
         scrub_ctr_reg <= '0;
         last_addr_reg <= '0;
      end else begin
         // R18 pending scrub dropped once scrub is disabled
         pend_reg <= pend_set || (pend_reg && !scr_fix && scrub_ok);
         if (scr_fix) begin
            scrub_ctr_reg <= scrub_ctr_reg + ADDR_W'(1);
            last_addr_reg <= scrub_ctr_reg;
         end
      end
   end

   // R13 busy and scrub status
   assign bus.memory_busy_n = !(state_reg == ST_SCR_WAIT
                                || state_reg == ST_SCR_READ || scr_fix);
   assign bus.scrub_active  = (state_reg == ST_SCR_READ) || scr_fix;
   assign bus.dq_dev        = dq_out_reg;
   assign bus.dq_dev_oe     = (state_reg == ST_HOLD) && !oe_n_s;
   assign bus.uncorrectable_flag = flag_reg;
   assign scrub_position    = last_addr_reg;
   assign control_word      = ctrl_reg;
endmodule: sedac_device

/* core/sedac_pkg.sv */
package sedac_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 32;
   localparam int CHK_W  = 7;
   localparam int SYN_W  = 6;
   localparam int CTRL_W = 12;
   localparam int WORDS  = 524288;
   localparam int CLK_MHZ = 200;

   // control word layout on the address lines
   localparam int BIT_RATE_LO    = 0;
   localparam int BIT_DLY_LO     = 4;
   localparam int BIT_CTR_RD     = 7;
   localparam int BIT_BYPASS     = 8;
   localparam int BIT_ACC_LO     = 9;
   localparam int BIT_ACC_HI     = 10;
   localparam int BIT_SCRUB_EN_N = 11;
   localparam logic [1:0] ACC_CTRL_WR = 2'h0;
   localparam logic [1:0] ACC_CTRL_RD = 2'h1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'hfff;
   // idle levels of the seven control pins: ce_n, we_n and request high
   localparam logic [6:0] PIN_CTL_IDLE = 7'h62;
   localparam logic [3:0] RATE_SEL_MAX = 4'hb;

   // fastest master scrub period, slower rates double per step
   localparam int SCRUB_FAST_NS  = 1126;
   localparam int SCRUB_FAST_CYC = SCRUB_FAST_NS * CLK_MHZ / 1000;
   localparam int TMR_W = 20;

   // busy to scrub delay, sixteen steps
   localparam int DLY_MIN_NS   = 80;
   localparam int DLY_MAX_NS   = 1600;
   localparam int DLY_MIN_CYC  = (DLY_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int DLY_MAX_CYC  = (DLY_MAX_NS * CLK_MHZ + 999) / 1000;
   localparam int DLY_STEP_CYC = (DLY_MAX_CYC - DLY_MIN_CYC) / 15;
   localparam int DLY_W = 9;

   // host side access shaping
   localparam int ACC_HOLD_CYC  = 12;
   localparam int ACC_GAP_CYC   = 3;
   localparam int SCRUB_REQ_CYC = 8;
   localparam int CNT_W = 5;

   typedef logic [ADDR_W-1:0] sedac_addr_t;
   typedef logic [DATA_W-1:0] sedac_data_t;
   typedef logic [CHK_W-1:0]  sedac_chk_t;
endpackage: sedac_pkg

/* core/sedac_if.sv */
`timescale 1ns/100ps
interface sedac_if;
   import sedac_pkg::*;
   sedac_addr_t addr;
   sedac_data_t dq_host;
   logic        dq_host_oe;
   sedac_data_t dq_dev;
   logic        dq_dev_oe;
   sedac_data_t dq_bus;
   logic        ce_n;
   logic        we_n;
   logic        oe_n;
   logic        reg_sel;
   logic        scrub_role_select;
   logic        scrub_request_n;
   logic        flag_single_sel;
   logic        memory_busy_n;
   logic        scrub_active;
   logic        uncorrectable_flag;

   // resolved data lines, zero when nobody drives
   assign dq_bus = dq_host_oe ? dq_host : (dq_dev_oe ? dq_dev : '0);

   modport dev (
      input  addr, dq_bus, ce_n, we_n, oe_n, reg_sel, scrub_role_select,
      input  scrub_request_n, flag_single_sel,
      output dq_dev, dq_dev_oe, memory_busy_n, scrub_active,
      output uncorrectable_flag
   );
   modport host (
      input  dq_bus, memory_busy_n, scrub_active, uncorrectable_flag,
      output addr, dq_host, dq_host_oe, ce_n, we_n, oe_n, reg_sel,
      output scrub_role_select, scrub_request_n, flag_single_sel
   );
endinterface: sedac_if

/* core/sedac_host.sv */
`timescale 1ns/100ps
module sedac_host
   import sedac_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   sedac_if.host                       bus,
   input  wire logic                   cmd_valid,
   input  wire logic                   cmd_write,
   input  wire logic                   cmd_reg,
   input  wire sedac_pkg::sedac_addr_t cmd_addr,
   input  wire sedac_pkg::sedac_data_t cmd_wdata,
   output logic                        cmd_ready,
   output logic                        rsp_valid,
   output sedac_pkg::sedac_data_t      rsp_data,
   output logic                        rsp_error,
   input  wire logic                   scrub_master,
   input  wire logic                   flag_on_single,
   input  wire logic                   scrub_pulse,
   output logic                        device_busy
);
   import sedac_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_GAP}
      sedac_host_state_t;

   localparam int IW = DATA_W + 3;

   sedac_host_state_t state_reg;
   wire  [IW-1:0]     in_raw;
   logic [IW-1:0]     in_s1_reg;
   logic [IW-1:0]     in_s2_reg;
   sedac_data_t       dq_s;
   logic              busy_n_s;
   logic              scrub_s;
   logic              flag_s;
   sedac_addr_t       addr_reg;
   sedac_data_t       wdata_reg;
   logic              we_n_reg;
   logic              reg_sel_reg;
   logic              ce_n_reg;
   logic              dq_oe_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic [CNT_W-1:0]  req_cnt_reg;
   logic              role_reg;
   logic              fsel_reg;
   logic              rsp_valid_reg;
   sedac_data_t       rsp_data_reg;
   logic              rsp_error_reg;

   assign in_raw = {bus.dq_bus, bus.memory_busy_n, bus.scrub_active,
                    bus.uncorrectable_flag};
   assign {dq_s, busy_n_s, scrub_s, flag_s} = in_s2_reg;

   // R13 no access while the device is busy
   assign cmd_ready = (state_reg == H_IDLE) && busy_n_s && !scrub_s
                      && (req_cnt_reg == '0);
   wire accept   = cmd_valid && cmd_ready;
   wire hold_end = cnt_reg == CNT_W'(ACC_HOLD_CYC - 1);
   wire gap_end  = cnt_reg == CNT_W'(ACC_GAP_CYC - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_s1_reg <= '0;
         in_s2_reg <= '0;
      end else begin
         in_s1_reg <= in_raw;
         in_s2_reg <= in_s1_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= H_IDLE;
         cnt_reg   <= '0;
         ce_n_reg  <= 1'b1;
         dq_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            H_IDLE: begin
               if (accept) begin
                  state_reg <= H_SETUP;
                  dq_oe_reg <= cmd_write && !cmd_reg;
               end
            end
            H_SETUP: begin
               state_reg <= H_STROBE;
               ce_n_reg  <= 1'b0;
               cnt_reg   <= '0;
            end
            H_STROBE: begin
               cnt_reg <= cnt_reg + CNT_W'(1);
               if (hold_end) begin
                  state_reg <= H_GAP;
                  ce_n_reg  <= 1'b1;
                  dq_oe_reg <= 1'b0;
                  cnt_reg   <= '0;
               end
            end
            H_GAP: begin
               cnt_reg <= cnt_reg + CNT_W'(1);
               if (gap_end) begin
                  state_reg <= H_IDLE;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   // R19 R20 control words ride on the address lines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_reg    <= '0;
         wdata_reg   <= '0;
         we_n_reg    <= 1'b1;
         reg_sel_reg <= 1'b0;
      end else if (accept) begin
         addr_reg    <= cmd_addr;
         wdata_reg   <= cmd_wdata;
         we_n_reg    <= !cmd_write;
         reg_sel_reg <= cmd_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg  <= '0;
         rsp_error_reg <= 1'b0;
      end else begin
         rsp_valid_reg <= (state_reg == H_STROBE) && hold_end;
         if ((state_reg == H_STROBE) && hold_end && we_n_reg) begin
            rsp_data_reg  <= dq_s;
            rsp_error_reg <= flag_s;
         end
      end
   end

   // R11 R14 R15 role level and request pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_cnt_reg <= '0;
         role_reg    <= 1'b0;
         fsel_reg    <= 1'b0;
      end else begin
         role_reg <= scrub_master;
         fsel_reg <= flag_on_single;
         if (req_cnt_reg != '0) begin
            req_cnt_reg <= req_cnt_reg - CNT_W'(1);
         end else if (scrub_pulse && (state_reg == H_IDLE)) begin
            req_cnt_reg <= CNT_W'(SCRUB_REQ_CYC);
         end
      end
   end

   assign bus.addr              = addr_reg;
   assign bus.dq_host           = wdata_reg;
   assign bus.dq_host_oe        = dq_oe_reg;
   assign bus.ce_n              = ce_n_reg;
   assign bus.we_n              = we_n_reg;
   assign bus.oe_n              = !we_n_reg;
   assign bus.reg_sel           = reg_sel_reg;
   assign bus.scrub_role_select = role_reg;
   assign bus.scrub_request_n   = req_cnt_reg == '0;
   assign bus.flag_single_sel   = fsel_reg;
   assign rsp_valid             = rsp_valid_reg;
   assign rsp_data              = rsp_data_reg;
   assign rsp_error             = rsp_error_reg;
   assign device_busy           = !busy_n_s || scrub_s;
endmodule: sedac_host

/* sim/sedac_properties.sv */
`timescale 1ns/100ps
module sedac_properties
   import sedac_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     rst,
   input wire sedac_pkg::sedac_addr_t   addr,
   input wire logic                     dq_host_oe,
   input wire logic                     dq_dev_oe,
   input wire logic                     ce_n,
   input wire logic                     we_n,
   input wire logic                     reg_sel,
   input wire logic                     scrub_role_select,
   input wire logic                     memory_busy_n,
   input wire logic                     scrub_active,
   input wire logic                     uncorrectable_flag,
   input wire sedac_pkg::sedac_addr_t   scrub_position,
   input wire logic [sedac_pkg::CTRL_W-1:0] control_word
);
   import sedac_pkg::*;

   int busy_cnt;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // length of each busy stretch
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         busy_cnt <= 0;
      else
         busy_cnt <= memory_busy_n ? 0 : busy_cnt + 1;
   end

   a_scrub_step:
      assert property ($changed(scrub_position) |->
         scrub_position == sedac_addr_t'($past(scrub_position) + 1'b1))
         else $error("scrub address did not step by one");
   a_scrub_busy:
      assert property (scrub_active |-> !memory_busy_n)
         else $error("scrub without busy");
   a_scrub_gate:
      assert property ($rose(scrub_active) |->
         !control_word[BIT_SCRUB_EN_N] && !control_word[BIT_BYPASS])
         else $error("scrub while disabled");
   a_scrub_len:
      assert property ($rose(scrub_active) |->
         scrub_active[*2] ##1 !scrub_active)
         else $error("scrub cycle length wrong");
   a_master_wait:
      assert property ($rose(scrub_active) && scrub_role_select |->
         $past(memory_busy_n, 8) == 1'b0)
         else $error("master scrub without busy lead");
   a_busy_bound:
      assert property (busy_cnt <= 330)
         else $error("busy held too long");
   a_no_contend:
      assert property (!(dq_dev_oe && dq_host_oe))
         else $error("both ends drive data");
   a_ctrl_write:
      assert property ($changed(control_word) |->
         $past(reg_sel, 2) && !$past(we_n, 2) && !$past(ce_n, 2) &&
         $past(addr[10:9], 2) == ACC_CTRL_WR &&
         control_word == $past(addr[11:0], 2))
         else $error("control word changed without write");
   a_flag_clear:
      assert property ($rose(ce_n) |-> ##[1:4] !uncorrectable_flag)
         else $error("flag not cleared after access");
endmodule: sedac_properties

/* sim/sram_error_correction_logic_scrub_engine_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); \
      end \
   end
module sram_error_correction_logic_scrub_engine_tb;
   import sedac_pkg::*;

   logic              clk;
   logic              rst;
   logic              cmd_valid;
   logic              cmd_write;
   logic              cmd_reg;
   sedac_addr_t       cmd_addr;
   sedac_data_t       cmd_wdata;
   logic              cmd_ready;
   logic              rsp_valid;
   sedac_data_t       rsp_data;
   logic              rsp_error;
   logic              scrub_master;
   logic              flag_on_single;
   logic              scrub_pulse;
   logic              device_busy;
   sedac_addr_t       scrub_position;
   logic [CTRL_W-1:0] control_word;
   sedac_data_t       q;
   logic              err_q;
   sedac_addr_t       p0;
   int                miscompares = 0;
   int                check_count = 0;
   int                rises = 0;
   int                r0;
   logic              act_q = 1'b0;
   logic [11:0]       off_cfg [2] = '{12'h900, 12'h800};

   sedac_if i_sedac_if ();

   sedac_device #(.SCRUB_FAST(8)) i_sedac_device (
      .clk            (clk),
      .rst            (rst),
      .bus            (i_sedac_if),
      .scrub_position (scrub_position),
      .control_word   (control_word)
   );

   sedac_host i_sedac_host (
      .clk            (clk),
      .rst            (rst),
      .bus            (i_sedac_if),
      .cmd_valid      (cmd_valid),
      .cmd_write      (cmd_write),
      .cmd_reg        (cmd_reg),
      .cmd_addr       (cmd_addr),
      .cmd_wdata      (cmd_wdata),
      .cmd_ready      (cmd_ready),
      .rsp_valid      (rsp_valid),
      .rsp_data       (rsp_data),
      .rsp_error      (rsp_error),
      .scrub_master   (scrub_master),
      .flag_on_single (flag_on_single),
      .scrub_pulse    (scrub_pulse),
      .device_busy    (device_busy)
   );

   sedac_properties i_sedac_properties (
      .clk                (clk),
      .rst                (rst),
      .addr               (i_sedac_if.addr),
      .dq_host_oe         (i_sedac_if.dq_host_oe),
      .dq_dev_oe          (i_sedac_if.dq_dev_oe),
      .ce_n               (i_sedac_if.ce_n),
      .we_n               (i_sedac_if.we_n),
      .reg_sel            (i_sedac_if.reg_sel),
      .scrub_role_select  (i_sedac_if.scrub_role_select),
      .memory_busy_n      (i_sedac_if.memory_busy_n),
      .scrub_active       (i_sedac_if.scrub_active),
      .uncorrectable_flag (i_sedac_if.uncorrectable_flag),
      .scrub_position     (scrub_position),
      .control_word       (control_word)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // count scrub cycles seen on the link
   always @(posedge clk) begin
      act_q <= i_sedac_if.scrub_active;
      if (i_sedac_if.scrub_active === 1'b1 && act_q === 1'b0)
         rises <= rises + 1;
   end

   function automatic sedac_data_t pat(input int i);
      return 32'h3c5a_0000 ^ (i * 32'h0010_2041);
   endfunction: pat

   function automatic sedac_addr_t adr(input int i);
      return (i < 8) ? sedac_addr_t'(i) : sedac_addr_t'(19'h7_fff6 + i);
   endfunction: adr

   task automatic report_and_stop;
      if (miscompares == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask: report_and_stop

   task automatic stall;
      miscompares++;
      report_and_stop();
   endtask: stall

   task automatic wait_ready;
      int n;
      n = 0;
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      if (n >= 600)
         stall();
   endtask: wait_ready

   task automatic acc(input logic w, input logic rg, input sedac_addr_t a,
                      input sedac_data_t d);
      int n;
      n = 0;
      cmd_write <= w;
      cmd_reg   <= rg;
      cmd_addr  <= a;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      wait_ready();
      @(posedge clk);
      cmd_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (n >= 40)
         stall();
      q     = rsp_data;
      err_q = rsp_error;
      @(posedge clk);
   endtask: acc

   task automatic ctrl(input logic [11:0] v);
      acc(1'b1, 1'b1, {7'h00, v}, '0);
   endtask: ctrl

   task automatic pulse_scrub;
      wait_ready();
      @(posedge clk);
      scrub_pulse <= 1'b1;
      @(posedge clk);
      scrub_pulse <= 1'b0;
   endtask: pulse_scrub

   task automatic wait_rises(input int t);
      int n;
      n = 0;
      while (rises < t && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000)
         stall();
   endtask: wait_rises

   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_reg = 1'b0;
      cmd_addr = '0;
      cmd_wdata = '0;
      scrub_master = 1'b0;
      flag_on_single = 1'b0;
      scrub_pulse = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK(control_word, CTRL_RST)
      ctrl(12'h800);
      `CHK(control_word, 12'h800)
      acc(1'b0, 1'b1, 19'h0_0200, '0);
      `CHK(q, 32'h0000_0800)
      for (int i = 0; i < 10; i++)
         acc(1'b1, 1'b0, adr(i), pat(i));
      for (int i = 0; i < 10; i++) begin
         flag_on_single <= i[0];
         acc(1'b0, 1'b0, adr(i), '0);
         `CHK(q, pat(i))
         `CHK(err_q, 1'b0)
      end
      // manual scrub, read then write back
      acc(1'b0, 1'b0, adr(5), '0);
      acc(1'b1, 1'b0, adr(5), q);
      acc(1'b0, 1'b0, adr(5), '0);
      `CHK(q, pat(5))
      // slave mode, one scrub per request
      ctrl(12'h000);
      acc(1'b0, 1'b1, 19'h0_0480, '0);
      `CHK(q[31:19], 13'h0000)
      p0 = q[18:0];
      r0 = rises;
      for (int k = 1; k <= 3; k++) begin
         pulse_scrub();
         wait_rises(r0 + k);
      end
      acc(1'b0, 1'b1, 19'h0_0480, '0);
      // first scrub lands on address zero, the counter's start value
      `CHK(q[18:0], sedac_addr_t'(p0 + 2))
      `CHK(rises - r0, 3)
      p0 = sedac_addr_t'(p0 + 2);
      // bypass with enable high, then enable high alone: requests ignored
      for (int k = 0; k < 2; k++) begin
         ctrl(off_cfg[k]);
         acc(1'b0, 1'b0, adr(k), '0);
         `CHK(q, pat(k))
         r0 = rises;
         pulse_scrub();
         repeat (4 * SCRUB_REQ_CYC) @(posedge clk);
         `CHK(rises, r0)
      end
      // master burst at rate step four, ended by the bench
      ctrl(12'h004);
      r0 = rises;
      scrub_master <= 1'b1;
      wait_rises(r0 + 4);
      ctrl(12'h800);
      scrub_master <= 1'b0;
      acc(1'b0, 1'b1, 19'h0_0480, '0);
      `CHK(q[18:0], sedac_addr_t'(p0 + rises - r0))
      `CHK(scrub_position, sedac_addr_t'(p0 + rises - r0))
      `CHK(device_busy, 1'b0)
      report_and_stop();
   end
endmodule: sram_error_correction_logic_scrub_engine_tb
